// file: pkg/ntf_pkg.sv
// Shared definitions for the nine-track frame formatter.
// Assumes a 32-bit APB slave and a head that moves one frame per clock.
package ntf_pkg;

   // ----------------------------------------
   // Geometry
   // ----------------------------------------
   localparam int WORD_W = 30;
   localparam int DELAY_N = 8;
   localparam logic [5:0] FRAME_BITS = 6'h08;
   localparam logic [5:0] WORD_BITS = 6'h1e;
   localparam logic [3:0] DIAG_POS = 4'h4;
   localparam logic [3:0] TAIL_LEN = 4'h8;
   localparam logic [3:0] FILL_MAX = 4'h8;
   localparam logic [1:0] GROUP_WORDS = 2'h3;
   localparam logic [3:0] GROUP_FRAMES = 4'he;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_WCOUNT = 8'h04;
   localparam logic [7:0] OFF_WDATA = 8'h08;
   localparam logic [7:0] OFF_RDATA = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_MASK = 8'h14;
   localparam logic [7:0] OFF_STATE = 8'h18;
   localparam int CTRL_WRITE = 0;
   localparam int CTRL_READ = 1;
   localparam int CTRL_BOOT = 2;
   localparam int CTRL_NINE = 10;
   localparam int ST_DONE = 0;
   localparam int ST_PARERR = 1;
   localparam int ST_RDWORD = 2;
   localparam int ST_OVERRUN = 3;
   localparam logic [3:0] STATUS_RST = 4'h0;
   localparam logic [3:0] MASK_RST = 4'h0;
   localparam logic [15:0] WCOUNT_RST = 16'h0000;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      IDLE = 3'b000,
      WAIT_WORD = 3'b001,
      EMIT = 3'b011,
      TAIL = 3'b010,
      READ = 3'b110
   } ntf_fsm_type;

   typedef struct packed {
      logic valid;
      logic blank;
      logic [8:0] bits;
   } ntf_frame_type;

   typedef struct packed {
      logic valid;
      logic last;
      logic [8:0] bits;
   } ntf_head_in_type;

   typedef logic [DELAY_N-1:0][8:0] ntf_taps_type;

   // Bit 8 makes the frame odd
   function automatic logic [8:0] ntf_add_parity(input logic [7:0] d);
      return {~^d, d};
   endfunction : ntf_add_parity

   function automatic logic ntf_mapped(input logic [7:0] a);
      return (a == OFF_CTRL) || (a == OFF_WCOUNT) || (a == OFF_WDATA) || (a == OFF_RDATA)
         || (a == OFF_STATUS) || (a == OFF_MASK) || (a == OFF_STATE);
   endfunction : ntf_mapped

endpackage : ntf_pkg

// file: core/ntf_check_calc.sv
// Running diagonal and longitudinal check values for one block.
// Assumes the caller clears it at block start and feeds data frames only.
`timescale 1ns/100ps
module ntf_check_calc (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Frame feed
   input wire logic clear,
   input wire logic update,
   input wire logic [8:0] frame,
   // Check values
   output logic [8:0] diag,
   output logic [8:0] lrc
);
   import ntf_pkg::*;

   typedef struct packed {
      logic [8:0] diag;
      logic [8:0] lrc;
   } ntf_chk_type;

   ntf_chk_type st;
   ntf_chk_type next_st;

   // Diagonal: rotate one track per frame, so a skewed bit lands elsewhere
   always_comb begin
      next_st = st;
      if (clear) begin
         next_st = '0;
      end else if (update) begin
         next_st.diag = {st.diag[7:0], st.diag[8]} ^ frame; // [RULE3] [RULE17]
         next_st.lrc = st.lrc ^ frame;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign diag = st.diag;
   assign lrc = st.lrc;

   a_diag_step: // [RULE3]
      assert property (@(posedge clk) disable iff (!resetn)
         (update && !clear) |=> diag == ({$past(diag[7:0]), $past(diag[8])} ^ $past(frame)))
      else $error("diagonal check not updated by frame");

endmodule : ntf_check_calc

// file: core/ntf_delay_line.sv
// Eight-frame delay line; the oldest frame leaves once the line is full.
// Assumes gap and check frames fill the last eight positions of a block.
`timescale 1ns/100ps
module ntf_delay_line (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Frame stream
   input wire logic clear,
   input wire logic shift,
   input wire logic [8:0] frameIn,
   // Held frames, index 0 newest
   output ntf_pkg::ntf_taps_type taps,
   output logic full
);
   import ntf_pkg::*;

   typedef struct packed {
      ntf_taps_type taps;
      logic [3:0] fill;
   } ntf_dl_type;

   ntf_dl_type st;
   ntf_dl_type next_st;

   always_comb begin
      next_st = st;
      if (clear) begin
         next_st = '0;
      end else if (shift) begin
         next_st.taps = {st.taps[DELAY_N-2:0], frameIn};
         if (st.fill != FILL_MAX) begin
            next_st.fill = st.fill + 4'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign taps = st.taps;
   assign full = (st.fill == FILL_MAX);

endmodule : ntf_delay_line

// file: core/ntf_formatter.sv
// Nine-track frame formatter: word/frame packing, check frames, APB registers.
// Assumes an APB master on the same clock and a head taking one frame a clock.
//
// Contract
// (RULE1) Each data frame is eight data bits plus a bit giving odd parity.
// (RULE2) Four words become fifteen frames on write, and back again on read.
// (RULE3) A nine-bit diagonal check value is updated with every data frame written.
// (RULE4) The diagonal check frame sits four positions after the last data frame.
// (RULE5) The longitudinal check frame sits eight positions after the last data frame.
// (RULE6) Forward read recomputes both checks and flags parity error on any mismatch.
// (RULE7) Nine-track handling always uses 800 frames per inch and odd parity.
// (RULE8) Bit 10 of a transfer function word selects nine-track, except bootstrap.
// (RULE9) Bootstrap takes its track format from the format switch input.
// (RULE10) Software asks for odd parity and 800 fpi on nine-track transfers.
// (RULE11) Software does not ask for translation on nine-track transfers.
// (RULE12) No more than sixteen tape units are attached in total.
// (RULE13) Frames are packed most significant first, words split across frames.
// (RULE14) A write ending off a four-word boundary pads the last frame with zeros.
// (RULE15) A read ending off a fifteen-frame boundary zero-fills the last word.
// (RULE16) Tape motion waits for the first data word on a write.
// (RULE17) Diagonal check is a rotate-and-xor; gap positions are written blank.
`timescale 1ns/100ps
module ntf_formatter (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt
   output logic irq,
   // Panel switch
   input wire logic trackFormatSwitch,
   // Head side
   input wire ntf_pkg::ntf_head_in_type headIn,
   output ntf_pkg::ntf_frame_type headOut,
   output logic tapeMotion,
   output logic nineTrackSel,
   output logic density800
);
   import ntf_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      ntf_fsm_type fsm;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
      logic [3:0] status;
      logic [3:0] mask;
      logic [15:0] wordCount;
      logic [15:0] wordsLeft;
      logic [WORD_W-1:0] word;
      logic wordFull;
      logic [37:0] acc;
      logic [5:0] accBits;
      logic [3:0] tailCnt;
      ntf_frame_type out;
      logic motion;
      logic nineSel;
      logic density800;
      logic [WORD_W-1:0] rdWord;
      logic rdFull;
      logic [37:0] rAcc;
      logic [5:0] rBits;
   } ntf_core_type;

   ntf_core_type st;
   ntf_core_type next_st;

   logic apbAccess;
   logic chkClear;
   logic chkUpdate;
   logic [8:0] chkFrame;
   logic [8:0] chkDiag;
   logic [8:0] chkLrc;
   logic dlClear;
   logic dlShift;
   ntf_taps_type dlTaps;
   logic dlFull;
   logic wordTake;
   logic frameEmit;

   assign apbAccess = psel && penable && st.pready;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   ntf_check_calc u_check (
      .clk(clk),
      .resetn(resetn),
      .clear(chkClear),
      .update(chkUpdate),
      .frame(chkFrame),
      .diag(chkDiag),
      .lrc(chkLrc)
   );

   ntf_delay_line u_delay (
      .clk(clk),
      .resetn(resetn),
      .clear(dlClear),
      .shift(dlShift),
      .frameIn(headIn.bits),
      .taps(dlTaps),
      .full(dlFull)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [3:0] stSet;
      logic [3:0] stClr;
      logic [8:0] fr;
      logic [37:0] ra;
      logic [5:0] rb;
      next_st = st;
      stSet = '0;
      stClr = '0;
      fr = '0;
      ra = st.rAcc;
      rb = st.rBits;
      chkClear = 1'b0;
      chkUpdate = 1'b0;
      chkFrame = '0;
      dlClear = 1'b0;
      dlShift = 1'b0;
      wordTake = 1'b0;
      frameEmit = 1'b0;
      next_st.out = '0;

      // Access phase answers after one wait state
      next_st.pready = psel && penable && !st.pready;
      next_st.pslverr = 1'b0;
      if (psel && penable && !st.pready) begin
         next_st.pslverr = !ntf_mapped(paddr);
         next_st.prdata = '0;
         if (!pwrite) begin
            case (paddr)
               OFF_CTRL: next_st.prdata[CTRL_NINE] = st.nineSel;
               OFF_WCOUNT: next_st.prdata = {16'h0000, st.wordCount};
               OFF_RDATA: next_st.prdata = {2'h0, st.rdWord};
               OFF_STATUS: next_st.prdata = {28'h0000000, st.status};
               OFF_MASK: next_st.prdata = {28'h0000000, st.mask};
               OFF_STATE: next_st.prdata = {24'h000000, st.density800, st.fsm,
                  st.wordFull, st.rdFull, st.motion, st.nineSel};
               default: next_st.prdata = '0;
            endcase
         end
      end
      if (apbAccess && !pwrite && paddr == OFF_RDATA) begin
         next_st.rdFull = 1'b0;
      end

      unique case (st.fsm)
         IDLE: begin
         end
         WAIT_WORD: begin
            if (st.wordFull) begin
               next_st.fsm = EMIT;
               next_st.motion = 1'b1; // [RULE16]
            end
         end
         EMIT: begin
            if (st.accBits >= FRAME_BITS) begin
               fr = ntf_add_parity(st.acc[37:30]); // [RULE1] [RULE13]
               next_st.acc = {st.acc[29:0], 8'h00};
               next_st.accBits = st.accBits - FRAME_BITS;
               frameEmit = 1'b1;
            end else if (st.wordsLeft != 16'h0000) begin
               if (st.wordFull) begin
                  // Word lands right below the bits still waiting
                  next_st.acc = st.acc | ({st.word, 8'h00} >> st.accBits); // [RULE2] [RULE13]
                  next_st.accBits = st.accBits + WORD_BITS;
                  next_st.wordFull = 1'b0;
                  next_st.wordsLeft = st.wordsLeft - 16'h0001;
                  wordTake = 1'b1;
               end
            end else if (st.accBits != 6'h00) begin
               fr = ntf_add_parity(st.acc[37:30]); // [RULE14]
               next_st.acc = '0;
               next_st.accBits = '0;
            end else begin
               next_st.fsm = TAIL;
               next_st.tailCnt = '0;
            end
            if (fr != 9'h000) begin
               next_st.out = '{valid: 1'b1, blank: 1'b0, bits: fr};
               chkUpdate = 1'b1;
               chkFrame = fr;
            end
         end
         TAIL: begin
            next_st.tailCnt = st.tailCnt + 4'h1;
            next_st.out = '{valid: 1'b1, blank: 1'b1, bits: 9'h000}; // [RULE17]
            if (next_st.tailCnt == DIAG_POS) begin
               next_st.out = '{valid: 1'b1, blank: 1'b0, bits: chkDiag}; // [RULE4]
            end
            if (next_st.tailCnt == TAIL_LEN) begin
               next_st.out = '{valid: 1'b1, blank: 1'b0, bits: chkLrc}; // [RULE5]
               next_st.fsm = IDLE;
               next_st.motion = 1'b0;
               stSet[ST_DONE] = 1'b1;
            end
         end
         READ: begin
            if (headIn.valid) begin
               dlShift = 1'b1;
               // Last eight positions are gap and check frames, so data lags
               if (dlFull) begin
                  chkUpdate = 1'b1;
                  chkFrame = dlTaps[DELAY_N-1];
                  if (!(^dlTaps[DELAY_N-1])) begin
                     stSet[ST_PARERR] = 1'b1; // [RULE1] [RULE7]
                  end
                  ra = st.rAcc | ({dlTaps[DELAY_N-1][7:0], 30'h00000000} >> st.rBits);
                  rb = st.rBits + FRAME_BITS; // [RULE2]
                  if (rb >= WORD_BITS) begin
                     next_st.rdWord = ra[37:8];
                     stSet[ST_OVERRUN] = next_st.rdFull;
                     next_st.rdFull = 1'b1;
                     stSet[ST_RDWORD] = 1'b1;
                     ra = {ra[7:0], 30'h00000000};
                     rb = rb - WORD_BITS;
                  end
               end
            end else if (headIn.last) begin
               if (st.rBits != 6'h00) begin
                  next_st.rdWord = st.rAcc[37:8]; // [RULE15]
                  stSet[ST_OVERRUN] = next_st.rdFull;
                  next_st.rdFull = 1'b1;
                  stSet[ST_RDWORD] = 1'b1;
               end
               ra = '0;
               rb = '0;
               if (!dlFull || dlTaps[DIAG_POS] != chkDiag || dlTaps[0] != chkLrc) begin
                  stSet[ST_PARERR] = 1'b1; // [RULE6]
               end
               stSet[ST_DONE] = 1'b1;
               next_st.fsm = IDLE;
               next_st.motion = 1'b0;
            end
            next_st.rAcc = ra;
            next_st.rBits = rb;
         end
         default: next_st.fsm = IDLE;
      endcase

      // Register writes; a data word may refill the cycle it is taken
      if (apbAccess && pwrite) begin
         case (paddr)
            OFF_CTRL: begin
               if (st.fsm == IDLE && (pwdata[CTRL_WRITE] || pwdata[CTRL_READ])) begin
                  // Bootstrap ignores the function word's format bit
                  next_st.nineSel = pwdata[CTRL_BOOT] ? trackFormatSwitch // [RULE9]
                     : pwdata[CTRL_NINE]; // [RULE8]
                  chkClear = 1'b1;
                  if (next_st.nineSel && pwdata[CTRL_WRITE]) begin
                     next_st.fsm = WAIT_WORD;
                     next_st.wordsLeft = st.wordCount;
                     next_st.acc = '0;
                     next_st.accBits = '0;
                  end else if (next_st.nineSel) begin
                     next_st.fsm = READ;
                     next_st.motion = 1'b1;
                     next_st.rAcc = '0;
                     next_st.rBits = '0;
                     dlClear = 1'b1;
                  end
               end
            end
            OFF_WCOUNT: next_st.wordCount = pwdata[15:0];
            OFF_WDATA: begin
               if (next_st.wordFull) begin
                  stSet[ST_OVERRUN] = 1'b1;
               end else begin
                  next_st.word = pwdata[WORD_W-1:0];
                  next_st.wordFull = 1'b1;
               end
            end
            OFF_STATUS: stClr = pwdata[3:0];
            OFF_MASK: next_st.mask = pwdata[3:0];
            default: begin
            end
         endcase
      end

      // Set wins over a clear in the same cycle
      next_st.status = (st.status & ~stClr) | stSet;
      next_st.irq = |(next_st.status & next_st.mask);
      next_st.density800 = 1'b1; // [RULE7]
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.status <= STATUS_RST;
         st.mask <= MASK_RST;
         st.wordCount <= WCOUNT_RST;
         st.density800 <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign irq = st.irq;
   assign headOut = st.out;
   assign tapeMotion = st.motion;
   assign nineTrackSel = st.nineSel;
   assign density800 = st.density800;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [1:0] hWords;
   logic [3:0] hFrames;

   // Group counters: four words and fifteen frames must close together
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hWords <= '0;
         hFrames <= '0;
      end else if (chkClear) begin
         hWords <= '0;
         hFrames <= '0;
      end else begin
         if (wordTake) begin
            hWords <= (hWords == GROUP_WORDS) ? 2'h0 : hWords + 2'h1;
         end
         if (frameEmit) begin
            hFrames <= (hFrames == GROUP_FRAMES) ? 4'h0 : hFrames + 4'h1;
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_gap3;
      (st.out.valid && st.out.blank) [*3];
   endsequence

   sequence s_check(logic [8:0] v);
      st.out.valid && !st.out.blank && st.out.bits == v;
   endsequence

   a_frame_parity: // [RULE1]
      assert property (($past(st.fsm) == EMIT && st.out.valid) |-> ^st.out.bits)
      else $error("data frame without odd parity");

   a_group_close: // [RULE2]
      assert property ((st.fsm == EMIT && st.accBits == 6'h00 && hWords == 2'h0)
         |-> hFrames == 4'h0)
      else $error("four words did not give fifteen frames");

   a_diag_place: // [RULE4]
      assert property ($rose(st.fsm == TAIL) |=> s_gap3 ##1 s_check(chkDiag))
      else $error("diagonal check frame misplaced");

   a_lrc_place: // [RULE5]
      assert property ($rose(st.fsm == TAIL)
         |=> s_gap3 ##1 s_check(chkDiag) ##1 s_gap3 ##1 s_check(chkLrc))
      else $error("longitudinal check frame misplaced");

   a_read_mismatch: // [RULE6]
      assert property ((st.fsm == READ && headIn.last && !headIn.valid
         && (dlTaps[DIAG_POS] != chkDiag || dlTaps[0] != chkLrc)) |=> st.status[ST_PARERR])
      else $error("check mismatch not flagged");

   a_format_bit: // [RULE8]
      assert property ((apbAccess && pwrite && paddr == OFF_CTRL && st.fsm == IDLE
         && pwdata[CTRL_WRITE] && !pwdata[CTRL_BOOT]) |=> st.nineSel == $past(pwdata[CTRL_NINE]))
      else $error("format not taken from function word");

   a_format_switch: // [RULE9]
      assert property ((apbAccess && pwrite && paddr == OFF_CTRL && st.fsm == IDLE
         && pwdata[CTRL_BOOT] && (pwdata[CTRL_READ] || pwdata[CTRL_WRITE]))
         |=> st.nineSel == $past(trackFormatSwitch))
      else $error("bootstrap format not taken from switch");

   a_write_pad: // [RULE14]
      assert property (st.fsm == EMIT |-> (st.acc << st.accBits) == 38'h0)
      else $error("write padding bits not zero");

   a_read_pad: // [RULE15]
      assert property (st.fsm == READ |-> (st.rAcc << st.rBits) == 38'h0)
      else $error("read fill bits not zero");

   a_motion_wait: // [RULE16]
      assert property (st.fsm == WAIT_WORD |-> !st.motion ##1 (st.fsm != EMIT || st.motion))
      else $error("tape moved before first word");

endmodule : ntf_formatter

// file: verif/ntf_head_model.sv
// Tape head model: records written frames, replays them on request.
// Assumes at most one frame per clock on either side.
`timescale 1ns/100ps
module ntf_head_model (
   // Clock
   input wire logic clk,
   // Head side
   input wire ntf_pkg::ntf_frame_type headOut,
   output ntf_pkg::ntf_head_in_type headIn,
   // Bench control
   input wire logic play,
   input wire logic [8:0] flip,
   input wire logic [7:0] spacing
);
   import ntf_pkg::*;
   // One tape unit stands here, within the sixteen-unit limit
   logic [8:0] tape [0:63];
   int count = 0;
   int pos = -1;
   int wt = 0;
   initial headIn = '0;
   always @(posedge clk) begin
      headIn.valid <= 1'h0;
      headIn.last <= 1'h0;
      // Idle line inverts its bits every clock, so the stale frame shows every other clock
      headIn.bits <= ~headIn.bits;
      if (headOut.valid) begin
         tape[count] <= headOut.bits;
         count <= count + 1;
      end
      if (play) pos <= 0;
      else if (wt > 0) wt <= wt - 1;
      else if (pos >= 0 && pos < count) begin
         // Gap positions replay as frames too
         headIn.valid <= 1'h1;
         headIn.bits <= tape[pos] ^ (pos == 2 ? flip : 9'h000);
         pos <= pos + 1;
         wt <= spacing;
      end else if (pos == count) begin
         headIn.last <= 1'h1;
         pos <= -1;
      end
   end
endmodule : ntf_head_model

// file: verif/nine_track_frame_formatter_tb.sv
// Self-checking bench for the nine-track frame formatter.
// Assumes the head model beside it and a 250 MHz clock.
`timescale 1ns/100ps
module nine_track_frame_formatter_tb;
   import ntf_pkg::*;
   logic clk = 1'h0;
   logic resetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic trackFormatSwitch = 1'h0;
   ntf_head_in_type headIn;
   ntf_frame_type headOut;
   logic tapeMotion;
   logic nineTrackSel;
   logic density800;
   logic play = 1'h0;
   logic [8:0] flip = 9'h000;
   logic [7:0] spacing = 8'h00;
   int numErrors = 0;
   int nCompared = 0;
   logic [31:0] q;
   logic err;
   logic [159:0] s;
   logic [189:0] e;
   logic [8:0] expTape [27];
   logic [8:0] dg;
   logic [8:0] lr;
   logic [7:0] rowAddr [6] = '{OFF_CTRL, OFF_WCOUNT, OFF_STATUS, OFF_MASK, OFF_STATE, 8'h1c};
   logic [31:0] rowData [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h80, 32'h0};
   logic rowErr [6] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};

   always #2 clk = ~clk;

   ntf_formatter ntf_formatter_inst (.clk(clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .trackFormatSwitch(trackFormatSwitch), .headIn(headIn), .headOut(headOut),
      .tapeMotion(tapeMotion), .nineTrackSel(nineTrackSel), .density800(density800));
   ntf_head_model ntf_head_model_inst (.clk(clk), .headOut(headOut), .headIn(headIn),
      .play(play), .flip(flip), .spacing(spacing));

   // ------
   // Tasks
   // ------
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      nCompared++;
      if (seen !== exp) begin
         numErrors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check

   // Waits on pready without limit; the watchdog ends a hang
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask : apb

   task automatic rdChk(input logic [7:0] a, input logic [39:0] x);
      apb(1'h0, a, 32'h0);
      check({err, q}, x);
   endtask : rdChk

   task automatic poll(input logic [7:0] a, input int b, input logic v);
      do apb(1'h0, a, 32'h0); while (q[b] !== v);
   endtask : poll

   task automatic startRead;
      // Odd parity, 800 fpi, no translation
      apb(1'h1, OFF_CTRL, 32'h402);
      play <= 1'h1;
      @(posedge clk);
      play <= 1'h0;
   endtask : startRead

   task automatic giveVerdict;
      $display("compared %0d, mismatches %0d", nCompared, numErrors);
      if (numErrors == 0 && nCompared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : giveVerdict

   // Whole run needs under two thousand cycles; this leaves ample slack
   initial begin
      #(200000);
      numErrors++;
      giveVerdict();
   end

   // ------
   // Tests
   // ------
   initial begin
      s = {30'h3ad51c27, 30'h12345678, 30'h2b6e0f91, 30'h0c3a5d1e, 30'h35f0a4c3, 10'h0};
      e = {s, 30'h0};
      dg = 9'h0;
      lr = 9'h0;
      for (int k = 0; k < 27; k++) expTape[k] = 9'h0;
      for (int k = 0; k < 19; k++) begin
         expTape[k] = {~^s[159-8*k -: 8], s[159-8*k -: 8]};
         dg = {dg[7:0], dg[8]} ^ expTape[k];
         lr = lr ^ expTape[k];
      end
      expTape[22] = dg;
      expTape[26] = lr;
      repeat (8) @(posedge clk);
      check({irq, tapeMotion, headOut.valid, density800}, 40'h1);
      resetn <= 1'h1;
      @(posedge clk);
      for (int i = 0; i < 6; i++) rdChk(rowAddr[i], {rowErr[i], rowData[i]});
      $display("test registers done");
      rdChk(OFF_CTRL, 40'h0);
      apb(1'h1, OFF_CTRL, 32'h1);
      rdChk(OFF_STATE, 40'h80);
      apb(1'h1, OFF_CTRL, 32'h405);
      rdChk(OFF_STATE, 40'h80);
      $display("test refusal done");
      apb(1'h1, OFF_MASK, 32'h1);
      apb(1'h1, OFF_WCOUNT, 32'h5);
      trackFormatSwitch <= 1'h1;
      apb(1'h1, OFF_CTRL, 32'h5);
      rdChk(OFF_STATE, 40'h91);
      repeat (10) @(posedge clk);
      check(tapeMotion, 40'h0);
      for (int i = 0; i < 5; i++) begin
         poll(OFF_STATE, 3, 1'h0);
         apb(1'h1, OFF_WDATA, {2'h0, s[159-30*i -: 30]});
      end
      for (int n = 0; n < 500 && irq !== 1'h1; n++) @(posedge clk);
      check(irq, 40'h1);
      // Model stores the last frame on this edge; let it settle first
      @(posedge clk);
      check(ntf_head_model_inst.count, 40'h1b);
      for (int k = 0; k < 27; k++)
         check(ntf_head_model_inst.tape[k], expTape[k]);
      rdChk(OFF_STATUS, 40'h1);
      apb(1'h1, OFF_STATUS, 32'h1);
      @(posedge clk);
      check(irq, 40'h0);
      $display("test write done");
      apb(1'h1, OFF_MASK, 32'h0);
      spacing <= 8'h1e;
      startRead();
      check(nineTrackSel, 40'h1);
      for (int i = 0; i < 6; i++) begin
         poll(OFF_STATUS, 2, 1'h1);
         apb(1'h0, OFF_RDATA, 32'h0);
         check(q[29:0], e[189-30*i -: 30]);
         apb(1'h1, OFF_STATUS, 32'h4);
      end
      poll(OFF_STATUS, 0, 1'h1);
      rdChk(OFF_STATUS, 40'h1);
      check(irq, 40'h0);
      $display("test read done");
      apb(1'h1, OFF_STATUS, 32'hf);
      flip <= 9'h003;
      spacing <= 8'h00;
      startRead();
      poll(OFF_STATUS, 0, 1'h1);
      check(q[1], 40'h1);
      $display("test bad check done");
      giveVerdict();
   end
endmodule : nine_track_frame_formatter_tb
